// ### hdl/mrf_pkg.sv
`default_nettype none
package mrf_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_RATE = 4'h8;

    // Control register field positions
    localparam int POS_RATE_B0 = 0;
    localparam int POS_RATE_B1 = 1;
    localparam int POS_FEC_B0 = 2;
    localparam int POS_FEC_B1 = 3;
    localparam int POS_SYNTH_SRC = 4;
    localparam int POS_BYPASS_EN = 5;
    localparam int POS_BYPASS_RX = 6;
    localparam int POS_STRENGTH = 8;
    localparam logic [11:0] CTRL_RESET = 12'h000;

    // Status register field positions
    localparam int POS_LOCKED = 0;
    localparam int POS_NEED_EXT = 1;
    localparam int POS_BAD_STRENGTH = 2;
    localparam int POS_M = 8;
    localparam int POS_N = 16;

    // Line rate codes, keyed as {bit0, bit1}
    typedef enum logic [1:0] {
        MRF_RATE_155 = 2'h0,
        MRF_RATE_622 = 2'h1,
        MRF_RATE_1244 = 2'h2,
        MRF_RATE_2488 = 2'h3
    } mrf_rate_e;

    // Serial clock ticks per bit enable for each line rate
    localparam logic [4:0] DIV_155 = 5'h10;
    localparam logic [4:0] DIV_622 = 5'h04;
    localparam logic [4:0] DIV_1244 = 5'h02;
    localparam logic [4:0] DIV_2488 = 5'h01;

    // Nominal hierarchy rates in kb/s
    localparam logic [31:0] KBPS_155 = 32'h00025F80;
    localparam logic [31:0] KBPS_622 = 32'h00097E00;
    localparam logic [31:0] KBPS_1244 = 32'h0012FC00;
    localparam logic [31:0] KBPS_2488 = 32'h0025F800;

    // Loop divider M and recovered-clock divider N
    localparam logic [4:0] DIV_17 = 5'h11;
    localparam logic [4:0] DIV_16 = 5'h10;
    localparam logic [4:0] DIV_15 = 5'h0F;
    localparam logic [4:0] DIV_14 = 5'h0E;
    localparam logic [4:0] DIV_ONE = 5'h01;

    // Correctable bytes per block, four bits wide so that eight fits
    localparam logic [3:0] STRENGTH_NONE = 4'h0;
    localparam logic [3:0] STRENGTH_MIN = 4'h3;
    localparam logic [3:0] STRENGTH_EXT_MAX = 4'h6;
    localparam logic [3:0] STRENGTH_MAX = 4'h8;

    // Top-rate frame geometry in bytes
    localparam logic [12:0] OH_BYTES = 13'h0090;
    localparam logic [12:0] PAYLOAD_BYTES = 13'h1050;
    localparam logic [12:0] ROW_BYTES = OH_BYTES + PAYLOAD_BYTES;
    localparam logic [3:0] ROWS = 4'h9;
    localparam logic [12:0] A2_FIRST = 13'h0030;
endpackage
`default_nettype wire

// ### hdl/mrf_synth.sv
`default_nettype none
// Credit-based rate multiplier: each source tick earns mult credits,
// each emitted tick spends div credits, so output rate is src * mult / div.
module mrf_synth #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Source and ratio
    input wire logic src_tick,
    input wire logic [4:0] mult,
    input wire logic [4:0] div,
    // Synthesized enable
    output logic out_tick
);
    if (W < 6) begin : g_bad_width
        $error("mrf_synth: W must hold at least two multiplier steps");
    end

    logic [W-1:0] credit;
    logic [W-1:0] next_credit;
    logic [W-1:0] add_w;
    logic [W-1:0] sub_w;

    // Emit while a whole divider's worth of credit is banked
    always_comb begin
        add_w = src_tick ? {{(W-5){1'b0}}, mult} : '0;
        out_tick = (credit >= {{(W-5){1'b0}}, div});
        sub_w = out_tick ? {{(W-5){1'b0}}, div} : '0;
        next_credit = credit + add_w - sub_w;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            credit <= '0;
        end else begin
            credit <= next_credit;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_synth_emits_after: assert property (
        (src_tick && credit == '0 && mult >= div) |=> out_tick)
        else $error("synthesizer missed a tick after source credit");
endmodule // mrf_synth
`default_nettype wire

// ### hdl/mrf_clock_select.sv
// Our own choices: the register addresses and the address-and-strobe port.
`default_nettype none
module mrf_clock_select #(
    parameter logic [7:0] FRAME_BYTE1 = 8'hF6,
    parameter logic [7:0] FRAME_BYTE2 = 8'h28,
    parameter int CREDIT_W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Clock enables in
    input wire logic reference_clock_in,
    input wire logic recovered_serial_clock,
    input wire logic external_bypass_clock,
    // Synthesizer and bit enables out
    output logic synthesized_serial_clock,
    output logic tx_bit_tick,
    // Transmit side
    input wire logic [15:0] tx_word,
    output logic tx_word_load,
    output logic tx_serial_out,
    // Receive side
    input wire logic rx_serial_in,
    output logic [15:0] rx_word,
    output logic rx_word_valid,
    // Frame status
    output logic frame_locked,
    output logic frame_start,
    output logic payload_envelope
);
    if (CREDIT_W < 6) begin : g_bad_credit
        $error("mrf_clock_select: CREDIT_W too small for the dividers");
    end

    typedef enum logic [1:0] {
        MRF_HUNT = 2'b01,
        MRF_SYNC = 2'b10
    } mrf_state_e;

    logic [11:0] ctrl;
    logic [11:0] next_ctrl;
    logic [31:0] next_rdata;
    logic [3:0] strength;
    logic synth_src;
    logic bypass_en;
    logic bypass_rx;
    mrf_pkg::mrf_rate_e rate;
    logic [4:0] rate_div;
    logic [31:0] rate_kbps;
    logic [4:0] loop_m;
    logic [4:0] rec_n;
    logic [4:0] synth_div;
    logic synth_in;
    logic serial_tick;
    logic need_ext;
    logic bad_strength;

    // Control fields
    always_comb begin
        strength = ctrl[mrf_pkg::POS_STRENGTH +: 4];
        synth_src = ctrl[mrf_pkg::POS_SYNTH_SRC];
        bypass_en = ctrl[mrf_pkg::POS_BYPASS_EN];
        bypass_rx = ctrl[mrf_pkg::POS_BYPASS_RX];
        rate = mrf_pkg::mrf_rate_e'({ctrl[mrf_pkg::POS_RATE_B0],
                                     ctrl[mrf_pkg::POS_RATE_B1]});
    end

    // Line rate decode: bit divider and nominal rate
    always_comb begin
        case (rate)
            mrf_pkg::MRF_RATE_155: begin
                rate_div = mrf_pkg::DIV_155;
                rate_kbps = mrf_pkg::KBPS_155;
            end
            mrf_pkg::MRF_RATE_622: begin
                rate_div = mrf_pkg::DIV_622;
                rate_kbps = mrf_pkg::KBPS_622;
            end
            mrf_pkg::MRF_RATE_1244: begin
                rate_div = mrf_pkg::DIV_1244;
                rate_kbps = mrf_pkg::KBPS_1244;
            end
            default: begin
                rate_div = mrf_pkg::DIV_2488;
                rate_kbps = mrf_pkg::KBPS_2488;
            end
        endcase
    end

    // Code rate decode, keyed as {bit0, bit1}
    always_comb begin
        case ({ctrl[mrf_pkg::POS_FEC_B0], ctrl[mrf_pkg::POS_FEC_B1]})
            2'b00: begin
                loop_m = mrf_pkg::DIV_17;
                rec_n = mrf_pkg::DIV_16;
            end
            2'b10: begin
                loop_m = mrf_pkg::DIV_16;
                rec_n = mrf_pkg::DIV_17;
            end
            2'b01: begin
                loop_m = mrf_pkg::DIV_15;
                rec_n = mrf_pkg::DIV_14;
            end
            default: begin
                loop_m = mrf_pkg::DIV_14;
                rec_n = mrf_pkg::DIV_15;
            end
        endcase
        // N only matters when the recovered clock feeds the loop
        synth_in = synth_src ? recovered_serial_clock : reference_clock_in;
        synth_div = synth_src ? rec_n : mrf_pkg::DIV_ONE;
    end

    // Code strength checks: only 8 and 7 come from the dividers
    always_comb begin
        bad_strength = (strength != mrf_pkg::STRENGTH_NONE)
                       && ((strength < mrf_pkg::STRENGTH_MIN)
                           || (strength > mrf_pkg::STRENGTH_MAX));
        need_ext = (strength >= mrf_pkg::STRENGTH_MIN)
                   && (strength <= mrf_pkg::STRENGTH_EXT_MAX)
                   && !(bypass_en && !bypass_rx);
    end

    mrf_synth #(
        .W(CREDIT_W)
    ) u_synth (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .src_tick(synth_in),
        .mult(loop_m),
        .div(synth_div),
        .out_tick(synthesized_serial_clock)
    );

    // Oscillator bypass picks the serial clock source
    always_comb begin
        if (bypass_en) begin
            serial_tick = bypass_rx ? recovered_serial_clock
                                    : external_bypass_clock;
        end else begin
            serial_tick = synthesized_serial_clock;
        end
    end

    // Register port: writes steer control, reads answer next cycle
    always_comb begin
        next_ctrl = ctrl;
        next_rdata = '0;
        if (reg_wr && reg_addr == mrf_pkg::ADDR_CTRL) begin
            next_ctrl = reg_wdata[11:0];
        end
        if (reg_rd) begin
            case (reg_addr)
                mrf_pkg::ADDR_CTRL: next_rdata = {20'h00000, ctrl};
                mrf_pkg::ADDR_STATUS: begin
                    next_rdata[mrf_pkg::POS_LOCKED] = frame_locked;
                    next_rdata[mrf_pkg::POS_NEED_EXT] = need_ext;
                    next_rdata[mrf_pkg::POS_BAD_STRENGTH] = bad_strength;
                    next_rdata[mrf_pkg::POS_M +: 5] = loop_m;
                    next_rdata[mrf_pkg::POS_N +: 5] = synth_div;
                end
                mrf_pkg::ADDR_RATE: next_rdata = rate_kbps;
                default: next_rdata = '0; // Unmapped reads return zero
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= mrf_pkg::CTRL_RESET;
            reg_rdata <= '0;
        end else begin
            ctrl <= next_ctrl;
            reg_rdata <= next_rdata;
        end
    end

    // Transmit path: rate divider, word load and shifter
    logic [4:0] rate_cnt;
    logic [4:0] next_rate_cnt;
    logic [3:0] tx_bit;
    logic [3:0] next_tx_bit;
    logic [15:0] tx_shift;
    logic [15:0] next_tx_shift;
    logic next_tx_out;

    always_comb begin
        next_rate_cnt = rate_cnt;
        tx_bit_tick = 1'b0;
        if (serial_tick) begin
            if (rate_cnt + 5'h01 >= rate_div) begin
                next_rate_cnt = '0;
                tx_bit_tick = 1'b1;
            end else begin
                next_rate_cnt = rate_cnt + 5'h01;
            end
        end
        tx_word_load = tx_bit_tick && (tx_bit == 4'hF);
        next_tx_bit = tx_bit_tick ? tx_bit + 4'h1 : tx_bit;
        next_tx_shift = tx_shift;
        next_tx_out = tx_serial_out;
        if (tx_word_load) begin
            next_tx_shift = {tx_word[14:0], 1'b0};
            next_tx_out = tx_word[15]; // Most significant bit first
        end else if (tx_bit_tick) begin
            next_tx_shift = {tx_shift[14:0], 1'b0};
            next_tx_out = tx_shift[15];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rate_cnt <= '0;
            tx_bit <= 4'hF; // First bit enable loads a word at once
            tx_shift <= '0;
            tx_serial_out <= 1'b0;
        end else begin
            rate_cnt <= next_rate_cnt;
            tx_bit <= next_tx_bit;
            tx_shift <= next_tx_shift;
            tx_serial_out <= next_tx_out;
        end
    end

    // Receive path: deserializer and frame alignment at the top rate
    mrf_state_e state;
    mrf_state_e next_state;
    logic [15:0] rx_shift;
    logic [15:0] next_rx_shift;
    logic [3:0] rx_bit;
    logic [3:0] next_rx_bit;
    logic [12:0] byte_pos;
    logic [12:0] next_byte_pos;
    logic [12:0] pos_adv;
    logic [3:0] row;
    logic [3:0] next_row;
    logic [15:0] next_rx_word;
    logic next_rx_valid;
    logic next_frame_start;
    logic next_payload;
    logic pattern_hit;
    logic top_rate;

    always_comb begin
        top_rate = (rate == mrf_pkg::MRF_RATE_2488);
        next_rx_shift = recovered_serial_clock ? {rx_shift[14:0], rx_serial_in} : rx_shift;
        pattern_hit = (next_rx_shift == {FRAME_BYTE1, FRAME_BYTE2});
        next_state = state;
        next_rx_bit = rx_bit;
        next_byte_pos = byte_pos;
        next_row = row;
        next_rx_word = rx_word;
        next_rx_valid = 1'b0;
        next_frame_start = 1'b0;
        next_payload = 1'b0;
        pos_adv = byte_pos + 13'h0002;
        if (!top_rate) begin
            next_state = MRF_HUNT; // Framing geometry only holds at the top rate
        end
        if (recovered_serial_clock) begin
            next_rx_bit = rx_bit + 4'h1;
            if (state == MRF_HUNT && top_rate && pattern_hit) begin
                // Word now holds the last first-pattern byte and first second one
                next_state = MRF_SYNC;
                next_rx_bit = '0;
                next_byte_pos = mrf_pkg::A2_FIRST + 13'h0001;
                next_row = '0;
                next_rx_word = next_rx_shift;
                next_rx_valid = 1'b1;
                next_frame_start = 1'b1;
            end else if (rx_bit == 4'hF) begin
                next_rx_word = next_rx_shift;
                next_rx_valid = 1'b1;
                if (state == MRF_SYNC && top_rate) begin
                    next_payload = (byte_pos >= mrf_pkg::OH_BYTES);
                    if (row == '0 && byte_pos == mrf_pkg::A2_FIRST - 13'h0001) begin
                        next_frame_start = pattern_hit;
                        if (!pattern_hit) begin
                            next_state = MRF_HUNT;
                        end
                    end
                    if (pos_adv >= mrf_pkg::ROW_BYTES) begin
                        next_byte_pos = pos_adv - mrf_pkg::ROW_BYTES;
                        next_row = (row + 4'h1 >= mrf_pkg::ROWS) ? 4'h0 : row + 4'h1;
                    end else begin
                        next_byte_pos = pos_adv;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= MRF_HUNT;
            rx_shift <= '0;
            rx_bit <= '0;
            byte_pos <= '0;
            row <= '0;
            rx_word <= '0;
            rx_word_valid <= 1'b0;
            frame_start <= 1'b0;
            payload_envelope <= 1'b0;
        end else begin
            state <= next_state;
            rx_shift <= next_rx_shift;
            rx_bit <= next_rx_bit;
            byte_pos <= next_byte_pos;
            row <= next_row;
            rx_word <= next_rx_word;
            rx_word_valid <= next_rx_valid;
            frame_start <= next_frame_start;
            payload_envelope <= next_payload;
        end
    end

    assign frame_locked = (state == MRF_SYNC);

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_rate_key_m_n: assert property (
        ({ctrl[mrf_pkg::POS_FEC_B0], ctrl[mrf_pkg::POS_FEC_B1]} == 2'b10)
        |-> (loop_m == 5'h10 && rec_n == 5'h11))
        else $error("code select 10 gave wrong dividers");
    a_ref_unity_div: assert property (
        (!synth_src && reg_rd && reg_addr == mrf_pkg::ADDR_STATUS)
        |=> reg_rdata[mrf_pkg::POS_N +: 5] == 5'h01)
        else $error("reference source did not read N as one");
    a_bypass_route: assert property (
        (bypass_en && !bypass_rx && external_bypass_clock && rate_div == 5'h01)
        |-> tx_bit_tick)
        else $error("external bypass clock not routed");
    a_ext_clock_flag: assert property (
        (strength == 4'h4 && !bypass_en && reg_rd && reg_addr == mrf_pkg::ADDR_STATUS)
        |=> reg_rdata[mrf_pkg::POS_NEED_EXT])
        else $error("external clock need not reported");
    a_tx_word_first_bit: assert property (
        tx_word_load |=> tx_serial_out == $past(tx_word[15]))
        else $error("loaded word did not start with its top bit");
    a_hunt_to_sync: assert property (
        (state == MRF_HUNT && top_rate && recovered_serial_clock && pattern_hit)
        |=> (frame_locked && rx_word_valid && frame_start
             && rx_word == {FRAME_BYTE1, FRAME_BYTE2}))
        else $error("framing pattern did not lock");
    a_lock_top_only: assert property (
        frame_locked |-> $past(top_rate))
        else $error("frame lock outside the top rate");
    a_rate_155_gap: assert property (
        (rate == mrf_pkg::MRF_RATE_155 && !bypass_en && tx_bit_tick && $stable(ctrl))
        |-> rate_cnt == 5'h0F)
        else $error("low rate bit enable not at sixteenth tick");
endmodule // mrf_clock_select
`default_nettype wire

// ### tb/mrf_framer_model.sv
`default_nettype none
// Upstream framer: offers a word on every load and checks the serial bit order
module mrf_framer_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Transmit handshake
    input wire logic tx_word_load,
    input wire logic tx_bit_tick,
    input wire logic tx_serial_out,
    output logic [15:0] tx_word,
    // Serial order tally
    output var int tx_checked,
    output var int tx_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] shadow;
    logic armed;
    logic tick_d;

    // Nothing is checked until a first load, since reset can cut a word short
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_word <= 16'hA5C3;
            shadow <= 16'h0000;
            armed <= 1'b0;
            tick_d <= 1'b0;
            tx_checked <= 0;
            tx_bad <= 0;
        end else begin
            tick_d <= tx_bit_tick;
            if (tick_d && armed) begin
                tx_checked <= tx_checked + 1;
                if (tx_serial_out !== shadow[15]) begin
                    tx_bad <= tx_bad + 1;
                end
                shadow <= {shadow[14:0], 1'b0};
            end
            // Word held steady until taken, then the next one is offered
            if (tx_bit_tick && tx_word_load) begin
                shadow <= tx_word;
                armed <= 1'b1;
                tx_word <= tx_word + 16'h3B1D;
            end
        end
    end
endmodule // mrf_framer_model
`default_nettype wire

// ### tb/tb_multirate_serdes_rate_fec_clock_select.sv
`default_nettype none
module tb_multirate_serdes_rate_fec_clock_select;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [2:0] src = 3'h0;
    logic rx_bit = 1'b0;
    logic [31:0] reg_rdata, rd_val;
    logic syn, tick, load, tx_out, rx_valid, locked, fstart, penv, pe_oh, pe_pl;
    logic [15:0] tx_word, rx_word, last_rx;
    int fails = 0, checked = 0, cyc = 0, n_syn = 0, n_tick = 0, fs_cnt = 0, since_fs = 0;
    int tx_checked, tx_bad;
    logic [4:0] m_tab [4] = '{mrf_pkg::DIV_17, mrf_pkg::DIV_15, mrf_pkg::DIV_16, mrf_pkg::DIV_14};
    logic [4:0] n_tab [4] = '{mrf_pkg::DIV_16, mrf_pkg::DIV_14, mrf_pkg::DIV_17, mrf_pkg::DIV_15};
    logic [4:0] d_tab [4] = '{mrf_pkg::DIV_155, mrf_pkg::DIV_622, mrf_pkg::DIV_1244,
        mrf_pkg::DIV_2488};
    logic [31:0] k_tab [4] = '{mrf_pkg::KBPS_155, mrf_pkg::KBPS_622, mrf_pkg::KBPS_1244,
        mrf_pkg::KBPS_2488};

    mrf_clock_select dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reference_clock_in(src[0]), .recovered_serial_clock(src[1]),
        .external_bypass_clock(src[2]), .synthesized_serial_clock(syn), .tx_bit_tick(tick),
        .tx_word(tx_word), .tx_word_load(load), .tx_serial_out(tx_out), .rx_serial_in(rx_bit),
        .rx_word(rx_word), .rx_word_valid(rx_valid), .frame_locked(locked),
        .frame_start(fstart), .payload_envelope(penv));

    mrf_framer_model framer (.clk_sys(clk_sys), .rst_n(rst_n), .tx_word_load(load),
        .tx_bit_tick(tick), .tx_serial_out(tx_out), .tx_word(tx_word),
        .tx_checked(tx_checked), .tx_bad(tx_bad));

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so take them there
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    task automatic pulse(input logic [2:0] which, input int n, input int gap);
        repeat (n) begin
            @(posedge clk_sys);
            src <= which;
            @(posedge clk_sys);
            src <= 3'h0;
            repeat (gap) @(posedge clk_sys);
        end
    endtask

    // Between bit pulses the line shows the inverse so a stale bit cannot pass
    task automatic send(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk_sys);
            src <= 3'h2;
            rx_bit <= w[i];
            @(posedge clk_sys);
            src <= 3'h0;
            rx_bit <= ~w[i];
        end
        repeat (4) @(posedge clk_sys);
    endtask

    // Pulse tallies, word monitor and hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (syn === 1'b1) n_syn++;
        if (tick === 1'b1) n_tick++;
        if (rx_valid === 1'b1) begin
            last_rx = rx_word;
            if (fstart === 1'b1) begin
                fs_cnt++;
                since_fs = 0;
            end else begin
                since_fs++;
            end
            // Word n after the pattern word starts at byte 47 + 2n; byte 143 ends overhead
            if (since_fs == 48) pe_oh = penv;
            if (since_fs == 49) pe_pl = penv;
        end
        if (cyc == LIMIT) begin
            fails++;
            $display("MISMATCH timeout expected done seen hang");
            results();
        end
    end

    initial begin
        do_reset();
        rd(mrf_pkg::ADDR_CTRL);
        check("ctrl reset", rd_val, {20'h0, mrf_pkg::CTRL_RESET});
        rd(mrf_pkg::ADDR_STATUS);
        check("status reset", rd_val, {11'h0, mrf_pkg::DIV_ONE, 3'h0, mrf_pkg::DIV_17, 8'h00});
        @(posedge clk_sys);
        #1 check("rdata idle", reg_rdata, 32'h0);
        rd(mrf_pkg::ADDR_RATE);
        check("rate reset", rd_val, mrf_pkg::KBPS_155);
        rd(4'hC);
        check("unmapped", rd_val, 32'h0);
        wr(mrf_pkg::ADDR_STATUS, 32'hFFFFFFFF);
        rd(mrf_pkg::ADDR_STATUS);
        check("status ro", rd_val, {11'h0, mrf_pkg::DIV_ONE, 3'h0, mrf_pkg::DIV_17, 8'h00});
        $display("test registers done");
        send(16'h1234);
        check("rx word", last_rx, 16'h1234);
        send(16'hF628);
        check("no frame low rate", fs_cnt, 0);
        check("no lock low rate", locked, 1'b0);
        $display("test free words done");
        // Code key is {bit0, bit1}, so k[1] lands in bit 2
        for (int k = 0; k < 4; k++) begin
            wr(mrf_pkg::ADDR_CTRL, {27'h0, 1'b1, k[0], k[1], 2'b00});
            rd(mrf_pkg::ADDR_STATUS);
            check("m n recovered", rd_val[20:8], {n_tab[k], 3'h0, m_tab[k]});
            wr(mrf_pkg::ADDR_CTRL, {28'h0, k[0], k[1], 2'b00});
            rd(mrf_pkg::ADDR_STATUS);
            check("m reference", rd_val[20:8], {mrf_pkg::DIV_ONE, 3'h0, m_tab[k]});
        end
        // Strengths 3 to 8 are legal; 3 to 6 need a clock that the dividers cannot make
        for (int s = 0; s < 16; s++) begin
            wr(mrf_pkg::ADDR_CTRL, {20'h0, s[3:0], 8'h00});
            rd(mrf_pkg::ADDR_STATUS);
            check("need ext", rd_val[1], s >= 3 && s <= 6);
            check("bad strength", rd_val[2], s == 1 || s == 2 || s > 8);
        end
        // The user supplies the external clock for the middle strengths
        wr(mrf_pkg::ADDR_CTRL, 32'h420);
        rd(mrf_pkg::ADDR_STATUS);
        check("ext supplied", rd_val[1], 1'b0);
        wr(mrf_pkg::ADDR_CTRL, 32'h460);
        rd(mrf_pkg::ADDR_STATUS);
        check("rx bypass", rd_val[1], 1'b1);
        $display("test dividers done");
        wr(mrf_pkg::ADDR_CTRL, 32'h10);
        #1 n_syn = 0;
        pulse(3'h2, 16, 20);
        check("synth recovered", n_syn, 17);
        wr(mrf_pkg::ADDR_CTRL, 32'h0);
        #1 n_syn = 0;
        pulse(3'h1, 1, 30);
        check("synth reference", n_syn, 17);
        wr(mrf_pkg::ADDR_CTRL, 32'h23);
        #1 n_tick = 0;
        n_syn = 0;
        pulse(3'h4, 5, 3);
        pulse(3'h1, 1, 30);
        check("ext bypass ticks", n_tick, 5);
        check("synth behind bypass", n_syn, 17);
        wr(mrf_pkg::ADDR_CTRL, 32'h63);
        #1 n_tick = 0;
        pulse(3'h2, 3, 3);
        pulse(3'h1, 1, 30);
        check("rx bypass ticks", n_tick, 3);
        $display("test synthesis done");
        // Fresh reset per rate keeps the bit divider phase known
        for (int r = 0; r < 4; r++) begin
            do_reset();
            wr(mrf_pkg::ADDR_CTRL, {29'h0, 1'b1, r[0], r[1]});
            rd(mrf_pkg::ADDR_RATE);
            check("rate", rd_val, k_tab[r]);
            n_tick = 0;
            pulse(3'h1, 4, 20);
            check("ticks per rate", n_tick, 64 / int'(d_tab[r]));
        end
        $display("test rates done");
        #1 fs_cnt = 0;
        send(16'h0000);
        send(16'hF628);
        repeat (49) send(16'h0000);
        check("frame start", fs_cnt, 1);
        check("lock", locked, 1'b1);
        check("last overhead", pe_oh, 1'b0);
        check("first payload", pe_pl, 1'b1);
        // Four reference pulses times M of 16 since the last reset give 64 bits
        check("tx bits seen", tx_checked, 64);
        check("tx order", tx_bad, 0);
        rd(mrf_pkg::ADDR_STATUS);
        check("status lock", rd_val[0], 1'b1);
        // Framing geometry holds only at the top rate, so leaving it drops lock
        wr(mrf_pkg::ADDR_CTRL, 32'h0);
        @(posedge clk_sys);
        #1 check("lock off top rate", locked, 1'b0);
        $display("test framing done");
        results();
    end
endmodule // tb_multirate_serdes_rate_fec_clock_select
`default_nettype wire
